//--- fsc_map.vh
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// Host clock period
`define FSC_CLK_NS      40

// Least strobe and gap times at the flag port
`define FSC_T_WR_NS     60
`define FSC_T_RD_NS     80
`define FSC_T_GAP_NS    40

// Least times rounded up to whole host cycles
`define FSC_WR_CYC      ((`FSC_T_WR_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_GAP_CYC     ((`FSC_T_GAP_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
// Read also covers the two-flop input synchroniser
`define FSC_RD_CYC      (((`FSC_T_RD_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS) + 2)

// Flag count and index width
`define FSC_FLAGS       8
`define FSC_IDX_W       3
`define FSC_LAST_IDX    3'h7

// User operations
`define FSC_OP_READ     2'h0
`define FSC_OP_CLAIM    2'h1
`define FSC_OP_RELEASE  2'h2
`define FSC_OP_INIT     2'h3

// Sequencer states
`define FSC_ST_IDLE     3'h0
`define FSC_ST_WSTB     3'h1
`define FSC_ST_WEND     3'h2
`define FSC_ST_GAP      3'h3
`define FSC_ST_READ     3'h4

`endif

//--- fsc_flag_host.v
`timescale 1ns/100ps
`include "fsc_map.vh"

// Functional notes
// - Between polled reads, select or output enable must go inactive.
// - Claim by writing zero, then reading back; never read before write.
// - After a failed claim keep reading or withdraw by writing one.
// - At power-up both sides write one to all eight flags.
module fsc_flag_host #(
  parameter [7:0] POLL_LIMIT = 8'h10
) (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_req_valid,
  input  wire [1:0]  i_op,
  input  wire [2:0]  i_index,
  output wire        o_req_ready,
  output reg         o_done,
  output reg         o_granted,
  output reg  [15:0] o_flag_value,
  output reg         o_flag_space_select_n,
  output reg         o_oe_n,
  output reg         o_rw_n,
  output reg  [2:0]  o_flag_index_lines,
  output reg  [15:0] o_data,
  output reg         o_data_oe_n,
  input  wire [15:0] i_data
);

  localparam integer WR_CYC_I  = `FSC_WR_CYC;
  localparam integer RD_CYC_I  = `FSC_RD_CYC;
  localparam integer GAP_CYC_I = `FSC_GAP_CYC;
  // Counts fit the eight-bit counter; upper bits dropped on purpose
  localparam [7:0]   WR_CYC    = WR_CYC_I[7:0];
  localparam [7:0]   RD_CYC    = RD_CYC_I[7:0];
  localparam [7:0]   GAP_CYC   = GAP_CYC_I[7:0];

  reg [2:0]  state;
  reg [7:0]  cnt;
  reg [1:0]  op;
  reg        after_read;
  reg        withdraw;
  reg [7:0]  polls;
  reg        init_pending;
  reg [15:0] data_meta;
  reg [15:0] data_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Data pins come from the far device, unrelated to our clock

  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
    end
    else
    begin
      data_meta <= i_data;
      data_sync <= data_meta;
    end
  end

  assign o_req_ready = (state == `FSC_ST_IDLE) && !init_pending;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sequences

  task start_write;
    input val;
    begin
      o_flag_space_select_n <= 1'b0;
      o_rw_n                <= 1'b0;
      o_oe_n                <= 1'b1;
      o_data                <= {16{val}};
      o_data_oe_n           <= 1'b0;
      cnt                   <= WR_CYC - 8'h01;
      state                 <= `FSC_ST_WSTB;
    end
  endtask

  task start_read;
    begin
      o_flag_space_select_n <= 1'b0;
      o_oe_n                <= 1'b0;
      o_rw_n                <= 1'b1;
      o_data_oe_n           <= 1'b1;
      cnt                   <= RD_CYC - 8'h01;
      state                 <= `FSC_ST_READ;
    end
  endtask

  task finish;
    begin
      o_done    <= 1'b1;
      // Low flag on our side means we hold the token
      o_granted <= ((op == `FSC_OP_CLAIM) || (op == `FSC_OP_READ)) &&
                   !o_flag_value[0];
      state     <= `FSC_ST_IDLE;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state                 <= `FSC_ST_IDLE;
      cnt                   <= 8'h00;
      op                    <= `FSC_OP_READ;
      after_read            <= 1'b0;
      withdraw              <= 1'b0;
      polls                 <= 8'h00;
      init_pending          <= 1'b1;
      o_done                <= 1'b0;
      o_granted             <= 1'b0;
      o_flag_value          <= 16'hffff;
      o_flag_space_select_n <= 1'b1;
      o_oe_n                <= 1'b1;
      o_rw_n                <= 1'b1;
      o_flag_index_lines    <= 3'h0;
      o_data                <= 16'hffff;
      o_data_oe_n           <= 1'b1;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        `FSC_ST_IDLE:
        begin
          withdraw <= 1'b0;
          polls    <= POLL_LIMIT;
          if (init_pending)
          begin
            // Flag state is random after power-up
            init_pending       <= 1'b0;
            op                 <= `FSC_OP_INIT;
            o_flag_index_lines <= 3'h0;
            start_write(1'b1);
          end
          else if (i_req_valid)
          begin
            op                 <= i_op;
            o_flag_index_lines <= i_index;
            if (i_op == `FSC_OP_READ)
              start_read;
            else if (i_op == `FSC_OP_INIT)
            begin
              o_flag_index_lines <= 3'h0;
              start_write(1'b1);
            end
            else
              start_write(i_op == `FSC_OP_RELEASE);
          end
        end
        `FSC_ST_WSTB:
        begin
          if (cnt == 8'h00)
          begin
            o_rw_n <= 1'b1;
            state  <= `FSC_ST_WEND;
          end
          else
            cnt <= cnt - 8'h01;
        end
        `FSC_ST_WEND:
        begin
          // Select and data held one cycle past the strobe edge
          o_flag_space_select_n <= 1'b1;
          o_data_oe_n           <= 1'b1;
          after_read            <= 1'b0;
          cnt                   <= GAP_CYC - 8'h01;
          state                 <= `FSC_ST_GAP;
        end
        `FSC_ST_READ:
        begin
          if (cnt == 8'h00)
          begin
            o_flag_value          <= data_sync;
            o_flag_space_select_n <= 1'b1;
            o_oe_n                <= 1'b1;
            after_read            <= 1'b1;
            cnt                   <= GAP_CYC - 8'h01;
            state                 <= `FSC_ST_GAP;
          end
          else
            cnt <= cnt - 8'h01;
        end
        `FSC_ST_GAP:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else if (after_read)
          begin
            if ((op == `FSC_OP_CLAIM) && o_flag_value[0])
            begin
              // Request is latched on the far side; keep polling while polls remain, then withdraw it by writing one
              if (polls != 8'h00)
              begin
                polls <= polls - 8'h01;
                start_read;
              end
              else
              begin
                withdraw <= 1'b1;
                start_write(1'b1);
              end
            end
            else
              finish;
          end
          else if ((op == `FSC_OP_CLAIM) && !withdraw)
            start_read;
          else if ((op == `FSC_OP_INIT) && (o_flag_index_lines != `FSC_LAST_IDX))
          begin
            o_flag_index_lines <= o_flag_index_lines + 3'h1;
            start_write(1'b1);
          end
          else
            finish;
        end
        default:
          state <= `FSC_ST_IDLE;
      endcase
    end
  end

endmodule // fsc_flag_host

//--- fsc_flag_host_chk.sv
`timescale 1ns/100ps
module fsc_flag_host_chk (
  input logic        i_clk,
  input logic        i_sys_rst,
  input logic        o_req_ready,
  input logic        o_flag_space_select_n,
  input logic        o_oe_n,
  input logic        o_rw_n,
  input logic [2:0]  o_flag_index_lines,
  input logic [15:0] o_data,
  input logic        o_data_oe_n
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_init_first: assert property ($fell(i_sys_rst) |=>
    !o_flag_space_select_n && !o_rw_n && o_data == 16'hffff && !o_req_ready)
    else $error("no init write");
  a_poll_gap: assert property ($fell(o_oe_n) |-> $past(o_flag_space_select_n))
    else $error("no gap");
  a_bus_drive: assert property (!o_rw_n |-> !o_data_oe_n)
    else $error("strobe without data");
  a_bus_release: assert property (!o_oe_n |-> o_data_oe_n)
    else $error("data driven in read");
  a_write_read: assert property ($rose(o_rw_n) && !o_data[0] |-> ##3
    !o_flag_space_select_n && !o_oe_n && o_flag_index_lines == $past(o_flag_index_lines, 3))
    else $error("no readback");
  a_strobe_width: assert property ($fell(o_rw_n) |=>
    !o_rw_n ##1 o_rw_n && !o_flag_space_select_n) else $error("bad strobe");
endmodule // fsc_flag_host_chk
////////////////////////////////////////////////////////////
bind fsc_flag_host fsc_flag_host_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .o_req_ready(o_req_ready), .o_flag_space_select_n(o_flag_space_select_n), .o_oe_n(o_oe_n),
  .o_rw_n(o_rw_n), .o_flag_index_lines(o_flag_index_lines), .o_data(o_data),
  .o_data_oe_n(o_data_oe_n));

//--- fsc_sem_model.sv
`timescale 1ns/100ps
module fsc_sem_model (
  input  wire        i_a_sel_n,
  input  wire        i_a_oe_n,
  input  wire        i_a_rw_n,
  input  wire [2:0]  i_a_idx,
  input  wire        i_a_d0,
  output wire [15:0] o_a_q,
  input  wire        i_b_sel_n,
  input  wire        i_b_oe_n,
  input  wire        i_b_rw_n,
  input  wire [2:0]  i_b_idx,
  input  wire        i_b_d0,
  output wire [15:0] o_b_q
);
  // Power-up junk: nothing clears the latches but the ports
  reg [7:0]  req_a = 8'h3c;
  reg [7:0]  req_b = 8'hc3;
  reg [1:0]  own [0:7];
  reg [15:0] qa;
  reg [15:0] qb;
  integer    k;
  integer    j;
  initial for (j = 0; j < 8; j = j + 1) own[j] = 2'h0;
  always @(posedge i_a_rw_n) if (!i_a_sel_n) req_a[i_a_idx] <= i_a_d0;
  always @(posedge i_b_rw_n) if (!i_b_sel_n) req_b[i_b_idx] <= i_b_d0;
  // Owner keeps the token until its own latch returns to one
  always @(req_a or req_b)
    for (k = 0; k < 8; k = k + 1)
      if (own[k] == 2'h0 || own[k] == 2'h1 && req_a[k] || own[k] == 2'h2 && req_b[k])
        own[k] = !req_a[k] ? 2'h1 : !req_b[k] ? 2'h2 : 2'h0;
  // Index may change in the same step as select; sample once it settles
  always @(negedge (i_a_sel_n | i_a_oe_n)) #1 qa <= {16{own[i_a_idx] != 2'h1}};
  always @(negedge (i_b_sel_n | i_b_oe_n)) #1 qb <= {16{own[i_b_idx] != 2'h2}};
  // Released bus shows the inverse so stale data cannot pass
  assign o_a_q = (i_a_sel_n | i_a_oe_n) ? ~qa : qa;
  assign o_b_q = (i_b_sel_n | i_b_oe_n) ? ~qb : qb;
endmodule // fsc_sem_model

//--- fsc_flag_host_tb.sv
`timescale 1ns/100ps
module fsc_flag_host_tb;
  reg         i_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg         i_req_valid = 1'b0;
  reg  [1:0]  i_op = 2'h0;
  reg  [2:0]  i_index = 3'h0;
  reg         b_sel_n = 1'b1;
  reg         b_rw_n = 1'b1;
  reg  [2:0]  b_idx = 3'h0;
  reg         b_d0 = 1'b1;
  wire        rdy, done, gnt, sel_n, oe_n, rw_n;
  wire [2:0]  idx;
  wire [15:0] val, wdat, rdat, b_q;
  integer     err_total = 0;
  integer     compares = 0;
  integer     seed = 4;
  integer     i;
  reg  [2:0]  f;
  always #20 i_clk = ~i_clk;
  fsc_flag_host #(.POLL_LIMIT(8'h02)) i_fsc_flag_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_req_valid(i_req_valid), .i_op(i_op), .i_index(i_index), .o_req_ready(rdy),
    .o_done(done), .o_granted(gnt), .o_flag_value(val), .o_flag_space_select_n(sel_n),
    .o_oe_n(oe_n), .o_rw_n(rw_n), .o_flag_index_lines(idx), .o_data(wdat),
    .o_data_oe_n(), .i_data(rdat));
  fsc_sem_model i_fsc_sem_model (.i_a_sel_n(sel_n), .i_a_oe_n(oe_n), .i_a_rw_n(rw_n),
    .i_a_idx(idx), .i_a_d0(wdat[0]), .o_a_q(rdat), .i_b_sel_n(b_sel_n), .i_b_oe_n(~b_rw_n),
    .i_b_rw_n(b_rw_n), .i_b_idx(b_idx), .i_b_d0(b_d0), .o_b_q(b_q));
  ////////////////////////////////////////////////////////////
  function [15:0] word(input b);
    word = {16{b}};
  endfunction
  task chk(input [15:0] a, input [15:0] e);
  begin
    compares = compares + 1;
    if (a !== e)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  end
  endtask
  task host(input [1:0] op, input [2:0] x, input g, input [15:0] v);
    integer n;
  begin
    i_op <= op;
    i_index <= x;
    i_req_valid <= 1'b1;
    n = 0;
    @(posedge i_clk);
    while (rdy !== 1'b1 && n < 300)
    begin
      n = n + 1;
      @(posedge i_clk);
    end
    i_req_valid <= 1'b0;
    while (done !== 1'b1 && n < 600)
    begin
      n = n + 1;
      @(posedge i_clk);
    end
    // A hung operation counts as a mismatch
    chk({15'h0, done}, 16'h0001);
    chk({15'h0, gnt}, {15'h0, g});
    if (op < 2'h2) chk(val, v);
  end
  endtask
  // Far port: reads keep rw high, so oe follows it
  task b_acc(input w, input [2:0] x, input d, input [15:0] e);
  begin
    b_idx <= x;
    b_d0 <= d;
    b_sel_n <= 1'b0;
    b_rw_n <= ~w;
    repeat (3) @(posedge i_clk);
    if (!w) chk(b_q, e);
    b_rw_n <= 1'b1;
    @(posedge i_clk);
    b_sel_n <= 1'b1;
    @(posedge i_clk);
  end
  endtask
  task finish_test;
  begin
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    err_total = err_total + 1;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) b_acc(1, i, 1, 0);
    host(0, 3'h0, 0, word(1));
    for (i = 0; i < 4; i = i + 1)
    begin
      f = 3'($random(seed));
      host(1, f, 1, word(0));
      b_acc(0, f, 0, word(1));
      b_acc(1, f, 0, 0);
      b_acc(0, f, 0, word(1));
      host(2, f, 0, 0);
      b_acc(0, f, 0, word(0));
      host(1, f, 0, word(1));
      b_acc(1, f, 1, 0);
      host(0, f, 0, word(1));
      $display("test %0d flag %0d ended", i, f);
    end
    host(1, 3'h7, 1, word(0));
    host(3, 3'h0, 0, 0);
    host(0, 3'h7, 0, word(1));
    finish_test;
  end
endmodule // fsc_flag_host_tb
